// file: hdl/art_pkg.sv
/*
  art_pkg: register map, field positions, reset values and the bus
  handshake states of the auto-reload pulse/capture timer.
  Assumes 32-bit APB data with one aligned word per 8-bit register.
*/
package art_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_RELOAD = 8'h08;
  localparam logic [7:0] OFF_PULSE = 8'h0C;
  localparam logic [7:0] OFF_DUTY0 = 8'h10;
  localparam logic [7:0] OFF_DUTY1 = 8'h14;
  localparam logic [7:0] OFF_DUTY2 = 8'h18;
  localparam logic [7:0] OFF_DUTY3 = 8'h1C;
  localparam logic [7:0] OFF_CAPCS = 8'h20;
  localparam logic [7:0] OFF_CAP1 = 8'h24;
  localparam logic [7:0] OFF_CAP2 = 8'h28;
  // ==========================================================
  // field positions
  localparam int CTRL_EXT = 7;
  localparam int CTRL_DIV_HI = 6;
  localparam int CTRL_DIV_LO = 4;
  localparam int CTRL_RUN = 3;
  localparam int CTRL_FRL = 2;
  localparam int CTRL_WIE = 1;
  localparam int CTRL_WF = 0;
  localparam int PULSE_OE_LO = 4;
  localparam int CAP_EDGE_LO = 4;
  localparam int CAP_IE_LO = 2;
  localparam int CAP_FLAG_LO = 0;
  // ==========================================================
  // sizes and values
  localparam int NCH = 4;
  localparam int NCAP = 2;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] RST8 = 8'h00;
  localparam logic [6:0] PRESC_RST = 7'h00;
  // ==========================================================
  // apb handshake states
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_DONE = 2'b10
  } apb_state_t;
endpackage : art_pkg

// file: hdl/auto_reload_pwm_capture_timer.sv
/*
  auto_reload_pwm_capture_timer: 8-bit auto-reload counter with 7-bit
  prescaler, four pulse outputs, two capture channels, APB slave.
  Assumes pins are asynchronous to pclk and the master follows APB.
  // Contract
  // (RULE_01) software stops counter before halt
  // (RULE_02) capture edge copies counter, sets flag
  // (RULE_03) no new capture until register read
  // (RULE_04) capture irq follows flag and enable
  // (RULE_05) edge select bits 5:4, 1 rising
  // (RULE_06) capture irq enables bits 3:2
  // (RULE_07) enabled capture edge wakes from halt
  // (RULE_08) bit 7 selects cpu or external clock
  // (RULE_09) bits 6:4 divide by power of two
  // (RULE_10) run bit freezes prescaler and counter
  // (RULE_11) force reload write-only, loads reload value
  // (RULE_12) wrap irq enable gates wrap irq
  // (RULE_13) wrap flag set at FFh, read clears
  // (RULE_14) counter access reads live, writes counter
  // (RULE_15) overflow reloads counter, switches pulse levels
  // (RULE_16) output enable bits 7:4 per channel
  // (RULE_17) polarity bits 3:0 set output levels
  // (RULE_18) polarity change inverts output at once
  // (RULE_19) duty register sets second edge
  // (RULE_20) capture status bits 7:6 read zero
  // (RULE_21) capture flag cleared by capture read
  // (RULE_22) compare reloaded from duty at overflow
  // (RULE_23) reset clears counter, prescaler, cpu clock
  // (RULE_24) counter increments per prescaler tick
  // (RULE_25) counter write or reload clears prescaler
  // (RULE_26) pins synchronised, edges detected on pclk
*/
`timescale 1ns/100ps
module auto_reload_pwm_capture_timer (
  input wire logic pclk, // bus and timer clock
  input wire logic presetn, // async reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic ext_clk_pin, // external counting clock
  input wire logic [1:0] capture_pin, // capture inputs, [0] is channel 1
  input wire logic halt_mode, // device sits in halt
  output logic [3:0] pulse_output_pin, // pulse levels
  output logic [3:0] pulse_oe_n, // pin driven while low
  output logic wrap_irq, // overflow interrupt request
  output logic [1:0] capture_irq, // capture interrupt requests
  output logic wake_req // one-cycle wake request from halt
);
  // ==========================================================
  // state
  art_pkg::apb_state_t state_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic ext_sel_q, count_run_q, wrap_irq_enable_q, wrap_flag_q;
  logic [2:0] divider_select_q;
  logic [7:0] count_q, reload_q, pulse_ctrl_q;
  logic [6:0] presc_q;
  logic [7:0] duty_q [art_pkg::NCH];
  logic [7:0] cmp_q [art_pkg::NCH];
  logic [1:0] edge_sel_q, cap_ie_q, cap_flag_q;
  logic [7:0] cap_val_q [art_pkg::NCAP];
  logic [2:0] s1_q, s2_q, s3_q, lvl_q; // [2] ext clock, [1:0] capture
  logic [3:0] pulse_q, oe_n_q;
  logic wrap_irq_q, wake_q;
  logic [1:0] cap_irq_q;

  // tap mask: all prescaler bits below tap n set
  function automatic logic [6:0] tap_mask(input logic [2:0] n);
    tap_mask = 7'((8'h01 << n) - 8'h01);
  endfunction : tap_mask

  // ==========================================================
  // bus strobes
  logic take, done, rd_take, wr_done;
  logic cnt_wr, frl_wr, ctrl_wr;
  logic [7:0] rd_mux;
  logic hit;
  logic [1:0] cap_rd;
  assign take = clk_en & psel & penable & (state_q == art_pkg::APB_IDLE);
  assign done = clk_en & psel & penable & (state_q == art_pkg::APB_DONE);
  assign rd_take = take & ~pwrite;
  assign wr_done = done & pwrite;
  assign ctrl_wr = wr_done & (paddr == art_pkg::OFF_CTRL);
  assign cnt_wr = wr_done & (paddr == art_pkg::OFF_COUNT);
  assign frl_wr = ctrl_wr & pwdata[art_pkg::CTRL_FRL];
  // clear-on-read acts when data is latched so nothing set later is lost
  assign cap_rd[0] = rd_take & (paddr == art_pkg::OFF_CAP1); // RULE_21
  assign cap_rd[1] = rd_take & (paddr == art_pkg::OFF_CAP2); // RULE_21

  // read mux and address decode
  always_comb begin
    rd_mux = art_pkg::RST8;
    hit = 1'b1;
    case (paddr)
      art_pkg::OFF_CTRL: rd_mux = {ext_sel_q, divider_select_q, count_run_q, 1'b0,
                                   wrap_irq_enable_q, wrap_flag_q}; // RULE_11
      art_pkg::OFF_COUNT: rd_mux = count_q; // RULE_14
      art_pkg::OFF_RELOAD: rd_mux = reload_q;
      art_pkg::OFF_PULSE: rd_mux = pulse_ctrl_q;
      art_pkg::OFF_DUTY0: rd_mux = duty_q[0];
      art_pkg::OFF_DUTY1: rd_mux = duty_q[1];
      art_pkg::OFF_DUTY2: rd_mux = duty_q[2];
      art_pkg::OFF_DUTY3: rd_mux = duty_q[3];
      art_pkg::OFF_CAPCS: rd_mux = {2'b00, edge_sel_q, cap_ie_q, cap_flag_q}; // RULE_20
      art_pkg::OFF_CAP1: rd_mux = cap_val_q[0];
      art_pkg::OFF_CAP2: rd_mux = cap_val_q[1];
      default: hit = 1'b0;
    endcase
  end

  // apb handshake: one wait state, data latched in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= art_pkg::APB_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (clk_en) begin
      case (state_q)
        art_pkg::APB_IDLE: begin
          if (psel && penable) begin
            state_q <= art_pkg::APB_DONE;
            pready_q <= 1'b1;
            pslverr_q <= ~hit;
            prdata_q <= pwrite ? 32'h00000000 : 32'(rd_mux);
          end
        end
        art_pkg::APB_DONE: begin
          state_q <= art_pkg::APB_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default: begin
          state_q <= art_pkg::APB_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // pin synchronisers: three stages, a change counts when 2 and 3 agree
  logic [2:0] stable_chg;
  assign stable_chg = ~(s2_q ^ s3_q) & (s2_q ^ lvl_q); // RULE_26
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      lvl_q <= 3'h0;
    end else if (clk_en) begin
      s1_q <= {ext_clk_pin, capture_pin}; // RULE_26
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_q ^ stable_chg;
    end
  end

  // ==========================================================
  // prescaler and counter ticks
  logic in_tick, cnt_tick, wrap_evt;
  logic [1:0] cap_evt, cap_go;
  assign in_tick = clk_en & count_run_q &
                   (ext_sel_q ? (stable_chg[2] & s2_q[2]) : 1'b1); // RULE_08 RULE_10
  // a counter tick is the carry into the selected tap
  assign cnt_tick = in_tick &
    ((presc_q & tap_mask(divider_select_q)) == tap_mask(divider_select_q)); // RULE_09
  assign wrap_evt = cnt_tick & (count_q == art_pkg::COUNT_MAX) & ~cnt_wr & ~frl_wr;
  // selected edge on each capture input
  assign cap_evt = {2{clk_en}} & stable_chg[1:0] & ~(s2_q[1:0] ^ edge_sel_q); // RULE_05
  // a pending flag blocks the copy unless it is being read now
  assign cap_go = cap_evt & (~cap_flag_q | cap_rd); // RULE_03

  // prescaler: counter write and forced reload restart it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= art_pkg::PRESC_RST; // RULE_23
    end else if (cnt_wr || frl_wr) begin
      presc_q <= art_pkg::PRESC_RST; // RULE_25
    end else if (in_tick) begin
      presc_q <= presc_q + 7'h01;
    end
  end

  // counter: bus write beats forced reload beats counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= art_pkg::RST8; // RULE_23
    end else if (cnt_wr) begin
      count_q <= pwdata[7:0]; // RULE_14
    end else if (frl_wr) begin
      count_q <= reload_q; // RULE_11
    end else if (wrap_evt) begin
      count_q <= reload_q; // RULE_15
    end else if (cnt_tick) begin
      count_q <= count_q + 8'h01; // RULE_24
    end
  end

  // ==========================================================
  // control register; force reload is a strobe and is never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sel_q <= 1'b0; // RULE_23
      divider_select_q <= 3'h0;
      count_run_q <= 1'b0;
      wrap_irq_enable_q <= 1'b0;
    end else if (ctrl_wr) begin
      ext_sel_q <= pwdata[art_pkg::CTRL_EXT]; // RULE_08
      divider_select_q <= pwdata[art_pkg::CTRL_DIV_HI:art_pkg::CTRL_DIV_LO]; // RULE_09
      count_run_q <= pwdata[art_pkg::CTRL_RUN]; // RULE_10
      wrap_irq_enable_q <= pwdata[art_pkg::CTRL_WIE]; // RULE_12
    end
  end

  // wrap flag: set wins over the clear by reading the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_flag_q <= 1'b0;
    end else if (wrap_evt) begin
      wrap_flag_q <= 1'b1; // RULE_13
    end else if (rd_take && paddr == art_pkg::OFF_CTRL) begin
      wrap_flag_q <= 1'b0; // RULE_13
    end
  end

  // reload, pulse control and duty registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= art_pkg::RST8;
      pulse_ctrl_q <= art_pkg::RST8;
      for (int i = 0; i < art_pkg::NCH; i++) begin
        duty_q[i] <= art_pkg::RST8;
      end
    end else if (wr_done) begin
      if (paddr == art_pkg::OFF_RELOAD) reload_q <= pwdata[7:0];
      if (paddr == art_pkg::OFF_PULSE) pulse_ctrl_q <= pwdata[7:0];
      if (paddr == art_pkg::OFF_DUTY0) duty_q[0] <= pwdata[7:0]; // RULE_19
      if (paddr == art_pkg::OFF_DUTY1) duty_q[1] <= pwdata[7:0];
      if (paddr == art_pkg::OFF_DUTY2) duty_q[2] <= pwdata[7:0];
      if (paddr == art_pkg::OFF_DUTY3) duty_q[3] <= pwdata[7:0];
    end
  end

  // hidden compare values follow duty only at overflow, so no glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < art_pkg::NCH; i++) begin
        cmp_q[i] <= art_pkg::RST8;
      end
    end else if (wrap_evt) begin
      for (int i = 0; i < art_pkg::NCH; i++) begin
        cmp_q[i] <= duty_q[i]; // RULE_22
      end
    end
  end

  // ==========================================================
  // pulse outputs: level from the buffered compare cmp_q, polarity applied directly
  // so a polarity write flips the pin on the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 4'h0;
      oe_n_q <= 4'hF;
    end else if (clk_en) begin
      for (int i = 0; i < art_pkg::NCH; i++) begin
        pulse_q[i] <= (count_q <= cmp_q[i]) ^ pulse_ctrl_q[i]; // RULE_15 RULE_17 RULE_18
        oe_n_q[i] <= ~pulse_ctrl_q[art_pkg::PULSE_OE_LO + i]; // RULE_16
      end
    end
  end

  // ==========================================================
  // capture control, flags and values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel_q <= 2'h0;
      cap_ie_q <= 2'h0;
    end else if (wr_done && paddr == art_pkg::OFF_CAPCS) begin
      edge_sel_q <= pwdata[art_pkg::CAP_EDGE_LO +: art_pkg::NCAP]; // RULE_05
      cap_ie_q <= pwdata[art_pkg::CAP_IE_LO +: art_pkg::NCAP]; // RULE_06
    end
  end

  // flags: a capture in the read cycle wins and the flag stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_flag_q <= 2'h0;
      for (int i = 0; i < art_pkg::NCAP; i++) begin
        cap_val_q[i] <= art_pkg::RST8;
      end
    end else begin
      cap_flag_q <= cap_go | (cap_flag_q & ~cap_rd); // RULE_02 RULE_21
      for (int i = 0; i < art_pkg::NCAP; i++) begin
        if (cap_go[i]) cap_val_q[i] <= count_q; // RULE_02
      end
    end
  end

  // ==========================================================
  // requests; interrupts lag their flags by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_irq_q <= 1'b0;
      cap_irq_q <= 2'h0;
      wake_q <= 1'b0;
    end else if (clk_en) begin
      wrap_irq_q <= wrap_flag_q & wrap_irq_enable_q; // RULE_12
      cap_irq_q <= cap_flag_q & cap_ie_q; // RULE_04
      wake_q <= halt_mode & |(cap_evt & cap_ie_q); // RULE_07
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pulse_output_pin = pulse_q;
  assign pulse_oe_n = oe_n_q;
  assign wrap_irq = wrap_irq_q;
  assign capture_irq = cap_irq_q;
  assign wake_req = wake_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_capture_loads: assert property (cap_evt[0] && !cap_flag_q[0] |=> // RULE_02
    cap_flag_q[0] && cap_val_q[0] == $past(count_q)) else $error("capture not taken");
  a_capture_blocks: assert property (cap_flag_q[1] && !cap_rd[1] |=> // RULE_03
    $stable(cap_val_q[1]) && cap_flag_q[1]) else $error("capture overwritten");
  a_capture_irq: assert property (clk_en |=> // RULE_04
    capture_irq == $past(cap_flag_q & cap_ie_q)) else $error("capture irq wrong");
  a_counter_frozen: assert property (!count_run_q && !cnt_wr && !frl_wr |=> // RULE_10
    $stable(count_q) && $stable(presc_q)) else $error("counter moved while stopped");
  a_force_reload: assert property (frl_wr && !cnt_wr |=> // RULE_11
    count_q == $past(reload_q) && presc_q == art_pkg::PRESC_RST) else $error("reload failed");
  a_wrap_reload: assert property (wrap_evt |=> // RULE_15
    count_q == $past(reload_q) && wrap_flag_q ##1 wrap_irq == wrap_irq_enable_q)
    else $error("overflow handling wrong");
  a_wrap_clear: assert property (rd_take && paddr == art_pkg::OFF_CTRL && !wrap_evt |=> // RULE_13
    !wrap_flag_q) else $error("wrap flag not cleared");
  a_count_write: assert property (cnt_wr |=> // RULE_14
    count_q == $past(pwdata[7:0]) && presc_q == art_pkg::PRESC_RST) else $error("count write lost");
  a_compare_hold: assert property (!wrap_evt |=> $stable(cmp_q[2])) // RULE_22
    else $error("compare changed off overflow");
  a_reserved_zero: assert property (rd_take && paddr == art_pkg::OFF_CAPCS |=> // RULE_20
    prdata[7:6] == 2'b00 && pready) else $error("reserved bits set");
  // counting, pin enables, wake gating and the clock-enable freeze
  a_count_step: assert property (cnt_tick && !wrap_evt && !cnt_wr && !frl_wr |=> // RULE_24
    count_q == $past(count_q) + 8'h01) else $error("counter did not step");
  a_oe_follow: assert property (clk_en |=> // RULE_16
    pulse_oe_n == ~$past(pulse_ctrl_q[art_pkg::PULSE_OE_LO +: art_pkg::NCH]))
    else $error("output enable wrong");
  a_wake_gate: assert property (clk_en && !halt_mode |=> !wake_req) // RULE_07
    else $error("wake outside halt");
  a_enable_freeze: assert property (!clk_en |=>
    $stable(count_q) && $stable(presc_q) && $stable(state_q)) else $error("state moved while disabled");

  c_capture: cover property (cap_go[0] ##[1:20] cap_rd[0]);
  c_wrap: cover property (wrap_evt ##1 wrap_flag_q);
  c_wake: cover property (wake_req);
  c_reload: cover property (frl_wr ##1 count_run_q);
  c_blocked: cover property (cap_flag_q[0] && cap_evt[0]);
endmodule : auto_reload_pwm_capture_timer

// file: bench/pin_model.sv
/*
  pin_model: the pins on the far side of the timer, driving the
  external counting clock and the two capture inputs.
  Assumes the timer samples its pins on the rising edge of pclk.
*/
`timescale 1ns/100ps
module pin_model (
  input wire logic pclk, // timer clock, paces every pin change
  output logic ext_clk_pin, // external counting clock
  output logic [1:0] capture_pin // capture inputs, [0] is channel 1
);
  // ==========================================================
  // idle levels: the counting clock stands low outside bursts
  initial begin
    ext_clk_pin = 1'b0;
    capture_pin = 2'b00;
  end

  // each pulse is high for four clocks and low for at least four, so the synchroniser sees it
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_clk_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask : ticks

  // one capture pin level change, then time for sync and capture to land
  task automatic set_cap(input int ch, input logic v);
    @(posedge pclk);
    capture_pin[ch] <= v;
    repeat (8) @(posedge pclk);
  endtask : set_cap
endmodule : pin_model

// file: bench/auto_reload_pwm_capture_timer_tb.sv
/*
  auto_reload_pwm_capture_timer_tb: register-level tests of the timer
  over APB, with pin_model on the pin side.
  Assumes the hand-over timing: one wait state per APB transfer.
*/
`timescale 1ns/100ps
module auto_reload_pwm_capture_timer_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_clk_pin, halt_mode = 1'b0, wrap_irq, wake_req;
  logic [1:0] capture_pin, capture_irq;
  logic [3:0] pulse_output_pin, pulse_oe_n;
  logic perr;
  logic wake_seen = 1'b0;
  logic [31:0] rd;
  int err_count = 0;
  int comparisons = 0;

  // ==========================================================
  // clock, device and pins
  always #20 pclk = ~pclk;

  auto_reload_pwm_capture_timer dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
    .capture_pin(capture_pin), .halt_mode(halt_mode), .pulse_output_pin(pulse_output_pin),
    .pulse_oe_n(pulse_oe_n), .wrap_irq(wrap_irq), .capture_irq(capture_irq),
    .wake_req(wake_req));

  pin_model pins (.pclk(pclk), .ext_clk_pin(ext_clk_pin), .capture_pin(capture_pin));

  // wake is a one-cycle pulse, so keep a sticky copy
  always @(posedge pclk) if (wake_req === 1'b1) wake_seen <= 1'b1;

  // ==========================================================
  // bus and compare tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held until pready is sampled high; bounded wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 1'b1, pready);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk("register read", {24'h0, exp}, rd);
  endtask : rdc

  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // watchdog: the tests need well under 10000 cycles
  initial begin
    #(40 * 30000);
    err_count++;
    wrap_up();
  end

  // ==========================================================
  // test sequence
  initial begin
    logic [7:0] offs [11];
    offs = '{art_pkg::OFF_CTRL, art_pkg::OFF_COUNT, art_pkg::OFF_RELOAD, art_pkg::OFF_PULSE,
      art_pkg::OFF_DUTY0, art_pkg::OFF_DUTY1, art_pkg::OFF_DUTY2, art_pkg::OFF_DUTY3,
      art_pkg::OFF_CAPCS, art_pkg::OFF_CAP1, art_pkg::OFF_CAP2};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values of the whole map
    foreach (offs[i]) rdc(offs[i], 8'h00);
    apb(1'b0, 8'h30, 8'h00);
    chk("unmapped error", 1'b1, perr);
    chk("unmapped data", 32'h0, rd);
    wr(art_pkg::OFF_DUTY0, 8'h80);
    rdc(art_pkg::OFF_DUTY0, 8'h80);
    // forced reload with the counter stopped
    wr(art_pkg::OFF_RELOAD, 8'hF0);
    wr(art_pkg::OFF_CTRL, 8'h04);
    rdc(art_pkg::OFF_CTRL, 8'h00);
    rdc(art_pkg::OFF_COUNT, 8'hF0);
    repeat (10) @(posedge pclk);
    rdc(art_pkg::OFF_COUNT, 8'hF0);
    // external clock across the wrap
    wr(art_pkg::OFF_COUNT, 8'hFE);
    wr(art_pkg::OFF_CTRL, 8'h8A);
    pins.ticks(3);
    rdc(art_pkg::OFF_COUNT, 8'hF1);
    chk("wrap irq", 1'b1, wrap_irq);
    rdc(art_pkg::OFF_CTRL, 8'h8B);
    rdc(art_pkg::OFF_CTRL, 8'h8A);
    chk("wrap irq clear", 1'b0, wrap_irq);
    // every divider code; a count write also clears the prescaler
    for (int dv = 0; dv < 8; dv++) begin
      wr(art_pkg::OFF_CTRL, 8'h88 | 8'(dv << 4));
      wr(art_pkg::OFF_COUNT, 8'h20);
      pins.ticks((1 << dv) - 1);
      rdc(art_pkg::OFF_COUNT, 8'h20);
      pins.ticks(1);
      rdc(art_pkg::OFF_COUNT, 8'h21);
    end
    // cpu clock source runs with no pin activity
    wr(art_pkg::OFF_COUNT, 8'h00);
    wr(art_pkg::OFF_CTRL, 8'h08);
    // enable low freezes the running count; only the four bus edges count
    clk_en <= 1'b0;
    repeat (10) @(posedge pclk);
    clk_en <= 1'b1;
    wr(art_pkg::OFF_CTRL, 8'h00);
    rdc(art_pkg::OFF_COUNT, 8'h04);
    // capture: ch1 rising with irq, ch2 falling without
    wr(art_pkg::OFF_COUNT, 8'h33);
    wr(art_pkg::OFF_CAPCS, 8'h14);
    pins.set_cap(0, 1'b1);
    rdc(art_pkg::OFF_CAPCS, 8'h15);
    chk("capture irq", 2'b01, capture_irq);
    wr(art_pkg::OFF_COUNT, 8'h44);
    pins.set_cap(0, 1'b0);
    pins.set_cap(0, 1'b1);
    rdc(art_pkg::OFF_CAP1, 8'h33);
    rdc(art_pkg::OFF_CAPCS, 8'h14);
    chk("capture irq clear", 2'b00, capture_irq);
    pins.set_cap(0, 1'b0);
    pins.set_cap(0, 1'b1);
    rdc(art_pkg::OFF_CAP1, 8'h44);
    pins.set_cap(1, 1'b1);
    rdc(art_pkg::OFF_CAPCS, 8'h14);
    pins.set_cap(1, 1'b0);
    rdc(art_pkg::OFF_CAPCS, 8'h16);
    chk("capture irq gated", 2'b00, capture_irq);
    rdc(art_pkg::OFF_CAP2, 8'h44);
    wr(art_pkg::OFF_CAPCS, 8'hFF);
    rdc(art_pkg::OFF_CAPCS, 8'h3C);
    // counter already stopped before halt, so no stray increments
    wr(art_pkg::OFF_CTRL, 8'h00);
    halt_mode <= 1'b1;
    pins.set_cap(1, 1'b1);
    chk("wake", 1'b1, wake_seen);
    halt_mode <= 1'b0;
    rdc(art_pkg::OFF_CAP2, 8'h44);
    // pulse outputs: compare only reloads at wrap
    wr(art_pkg::OFF_DUTY1, 8'hA0);
    wr(art_pkg::OFF_RELOAD, 8'h70);
    wr(art_pkg::OFF_COUNT, 8'h90);
    repeat (3) @(posedge pclk);
    chk("pulse before wrap", 4'b0000, pulse_output_pin);
    wr(art_pkg::OFF_COUNT, 8'hFF);
    wr(art_pkg::OFF_CTRL, 8'h88);
    pins.ticks(1);
    chk("pulse after wrap", 4'b0011, pulse_output_pin);
    chk("pins off", 4'hF, pulse_oe_n);
    wr(art_pkg::OFF_PULSE, 8'hFF);
    repeat (2) @(posedge pclk);
    chk("pulse inverted", 4'b1100, pulse_output_pin);
    chk("pins on", 4'h0, pulse_oe_n);
    wr(art_pkg::OFF_PULSE, 8'h5A);
    repeat (2) @(posedge pclk);
    chk("pulse mixed", 4'b1001, pulse_output_pin);
    chk("pins mixed", 4'b1010, pulse_oe_n);
    wrap_up();
  end
endmodule : auto_reload_pwm_capture_timer_tb
